// ---- shared/rsl_pkg.sv ----
// Shared constants and types for the serial command link slave
package rsl_pkg;

  // ------------------------------------------------------------
  // Clock and bit rates
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned BAUD_MIN      = 1200;
  localparam int unsigned BAUD_MAX      = 19200;
  localparam int unsigned BAUD_DEFAULT  = 9600;
  localparam int          RATE_W        = 3;
  localparam int          DIV_W         = 17;
  // Rate code n selects BAUD_MIN << n, so 0..4 spans 1200..19200
  localparam logic [2:0]  RATE_CODE_MAX = 3'h4;
  localparam logic [2:0]  RATE_CODE_DEF = 3'h3;

  // ------------------------------------------------------------
  // Character framing
  // ------------------------------------------------------------
  localparam int          DATA_BITS     = 8;
  localparam logic [3:0]  RX_SAMPLES    = 4'h9;
  localparam logic [3:0]  TX_LAST_BIT   = 4'hA;
  localparam logic        PARITY_ODD    = 1'b0;

  // ------------------------------------------------------------
  // Control characters
  // ------------------------------------------------------------
  localparam logic [7:0]  CHR_CR        = 8'h0D;
  localparam logic [7:0]  CHR_FF        = 8'h0C;
  localparam logic [7:0]  CHR_US        = 8'h1F;
  localparam logic [3:0][7:0] ACK_SEQ   = {CHR_CR, CHR_CR, CHR_US, CHR_FF};
  localparam logic [1:0]  ACK_LAST      = 2'h3;

  // ------------------------------------------------------------
  // Command buffer
  // ------------------------------------------------------------
  localparam int          CMD_DEPTH     = 32;
  localparam int          CMD_AW        = 5;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rsl_char_t;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } rsl_rsp_t;

  function automatic logic [DIV_W-1:0] rsl_bit_div(input logic [2:0] code);
    rsl_bit_div = DIV_W'(CLK_HZ / (BAUD_MIN << code));
  endfunction : rsl_bit_div

endpackage : rsl_pkg

// ---- hw/rsl_cmd_mem.sv ----
// Command character buffer with registered read port
`timescale 1ns/1ps
module rsl_cmd_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data_q
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // No reset on the array so it maps to plain RAM
  logic [W-1:0] mem_q [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data_q <= mem_q[rd_addr];
  end

endmodule : rsl_cmd_mem

// ---- hw/rsl_uart_rx.sv ----
// Character receiver: start, 8 data, parity, stop
`timescale 1ns/1ps
module rsl_uart_rx
  import rsl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_sync_b,
  input  wire logic              rxd,
  input  wire logic [DIV_W-1:0]  bit_div,
  output rsl_pkg::rsl_char_t     char_q,
  output logic                   frame_err_q
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rsl_rx_state_t;

  rsl_rx_state_t    state_q;
  logic [DIV_W-1:0] cnt_q;
  logic [3:0]       idx_q;
  logic [8:0]       sh_q;

  wire cnt_zero   = (cnt_q == '0);
  wire parity_ok  = ((^sh_q) == PARITY_ODD);
  wire [DIV_W-1:0] div_m1 = bit_div - DIV_W'(1);

  // ------------------------------------------------------------
  // Mid-bit sampling
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      state_q     <= RX_IDLE;
      cnt_q       <= '0;
      idx_q       <= '0;
      sh_q        <= '0;
      char_q      <= '0;
      frame_err_q <= 1'b0;
    end
    else
    begin
      char_q.valid <= 1'b0;
      frame_err_q  <= 1'b0;
      cnt_q        <= cnt_zero ? cnt_q : cnt_q - DIV_W'(1);
      case (state_q)
        RX_IDLE:
          if (!rxd)
          begin
            state_q <= RX_START;
            cnt_q   <= bit_div >> 1;
          end
        RX_START:
          if (cnt_zero)
          begin
            state_q <= rxd ? RX_IDLE : RX_BITS;
            cnt_q   <= div_m1;
            idx_q   <= '0;
          end
        RX_BITS:
          if (cnt_zero)
          begin
            sh_q    <= {rxd, sh_q[8:1]};
            idx_q   <= idx_q + 4'h1;
            cnt_q   <= div_m1;
            if (idx_q == RX_SAMPLES - 4'h1)
            begin
              state_q <= RX_STOP;
            end
          end
        RX_STOP:
          if (cnt_zero)
          begin
            state_q <= RX_IDLE;
            if (rxd && parity_ok)
            begin
              char_q.valid <= 1'b1;
              char_q.data  <= sh_q[7:0];
            end
            else
            begin
              frame_err_q <= 1'b1;
            end
          end
        default: state_q <= RX_IDLE;
      endcase
    end
  end

endmodule : rsl_uart_rx

// ---- hw/rsl_link_slave.sv ----
// Slave end of the four-wire serial command link
`timescale 1ns/1ps
module rsl_link_slave
  import rsl_pkg::*;
#(
  parameter int          DEPTH    = CMD_DEPTH,
  parameter int          AW       = CMD_AW,
  // Clock rate that all bit times are reckoned from
  parameter int unsigned CLK_FREQ = CLK_HZ
) (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     rxd,
  output logic                          txd,
  output logic                          drv_en,
  input  wire logic                     default_init_jumper,
  input  wire logic                     control_priority_jumper,
  input  wire logic [RATE_W-1:0]        saved_rate_code,
  input  wire logic                     rate_wr,
  input  wire logic [RATE_W-1:0]        rate_code,
  output logic      [RATE_W-1:0]        bit_rate_setting,
  output logic                          init_normal,
  output logic                          init_total,
  output logic                          cmd_valid,
  output logic      [AW:0]              cmd_len,
  input  wire logic [AW-1:0]            cmd_rd_addr,
  output logic      [7:0]               cmd_rd_data,
  input  wire logic                     cmd_done,
  output logic                          rx_err,
  input  wire logic                     ack_req,
  input  wire logic                     rsp_valid,
  input  wire rsl_pkg::rsl_rsp_t        rsp,
  output logic                          rsp_ready
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // Bit rate setting and jumper restore
  // ------------------------------------------------------------
  logic              strap_done_q;
  logic [RATE_W-1:0] rate_q;
  logic              init_normal_q;
  logic              init_total_q;

  wire saved_ok = (saved_rate_code <= RATE_CODE_MAX);
  wire wr_ok    = rate_wr && (rate_code <= RATE_CODE_MAX);
  wire [RATE_W-1:0] strap_rate = default_init_jumper ? RATE_CODE_DEF :
                                 (saved_ok ? saved_rate_code : RATE_CODE_DEF);
  // out of range codes are ignored
  wire [RATE_W-1:0] rate_d = !strap_done_q ? strap_rate :
                             (wr_ok ? rate_code : rate_q);

  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      rate_q        <= RATE_CODE_DEF;
      strap_done_q  <= 1'b0;
      init_normal_q <= 1'b0;
      init_total_q  <= 1'b0;
    end
    else
    begin
      strap_done_q  <= 1'b1;
      rate_q        <= rate_d;
      init_normal_q <= !strap_done_q && default_init_jumper && control_priority_jumper;
      init_total_q  <= !strap_done_q && default_init_jumper && !control_priority_jumper;
    end
  end

  assign bit_rate_setting = rate_q;
  assign init_normal      = init_normal_q;
  assign init_total       = init_total_q;

  // divisor fixed by the setting, never by the line
  // Constant table per rate code avoids a run-time divider
  logic [DIV_W-1:0] div_tab [2**RATE_W];

  for (genvar g = 0; g < 2**RATE_W; g++)
  begin : g_div
    assign div_tab[g] = DIV_W'(CLK_FREQ / (BAUD_MIN << g));
  end

  wire [DIV_W-1:0] bit_div = div_tab[rate_q];

  // ------------------------------------------------------------
  // Receive path
  // ------------------------------------------------------------
  rsl_char_t rx_char;
  logic      rx_err_w;

  // receiver runs regardless of transmit state
  rsl_uart_rx u_rx (
    .clk         (clk),
    .rst_sync_b  (rst_sync_q),
    .rxd         (rxd),
    .bit_div     (bit_div),
    .char_q      (rx_char),
    .frame_err_q (rx_err_w)
  );

  assign rx_err = rx_err_w;

  // ------------------------------------------------------------
  // Command buffer
  // ------------------------------------------------------------
  logic        pend_q;
  logic [AW:0] len_q;
  logic        owed_q;

  wire rx_take  = rx_char.valid && (!pend_q || cmd_done);
  wire rx_is_cr = (rx_char.data == CHR_CR);
  wire [AW:0] len_base = (pend_q && cmd_done) ? '0 : len_q;
  // Overflowing characters are dropped; the string still closes on CR
  wire room     = (len_base < (AW+1)'(DEPTH));
  wire buf_wr   = rx_take && !rx_is_cr && room;
  wire cmd_end  = rx_take && rx_is_cr;
  wire ans_start;

  rsl_cmd_mem #(
    .W     (8),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clk       (clk),
    .wr_en     (buf_wr),
    .wr_addr   (len_base[AW-1:0]),
    .wr_data   (rx_char.data),
    .rd_addr   (cmd_rd_addr),
    .rd_data_q (cmd_rd_data)
  );

  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      pend_q <= 1'b0;
      len_q  <= '0;
      owed_q <= 1'b0;
    end
    else
    begin
      // hand over on CR, clear on done
      pend_q <= cmd_end || (pend_q && !cmd_done);
      len_q  <= buf_wr ? len_base + (AW+1)'(1) : len_base;
      // reply allowed only after a command; new command wins
      owed_q <= cmd_end || (owed_q && !ans_start);
    end
  end

  assign cmd_valid = pend_q;
  assign cmd_len   = len_q;

  // ------------------------------------------------------------
  // Transmit sequencer
  // ------------------------------------------------------------
  typedef enum logic [2:0] {TS_IDLE, TS_ACK, TS_HEAD, TS_BODY, TS_TAIL, TS_DRAIN}
    rsl_tx_state_t;

  rsl_tx_state_t    ts_q;
  rsl_tx_state_t    ts_d;
  logic [1:0]       ack_idx_q;
  logic             busy_q;
  logic [10:0]      sh_q;
  logic [DIV_W-1:0] tcnt_q;
  logic [3:0]       tbit_q;
  logic             drv_q;

  wire start_ack = (ts_q == TS_IDLE) && owed_q && ack_req;
  wire start_rsp = (ts_q == TS_IDLE) && owed_q && !ack_req && rsp_valid;
  assign ans_start = start_ack || start_rsp;

  wire in_ack   = (ts_q == TS_ACK);
  wire in_body  = (ts_q == TS_BODY);
  wire in_cr    = (ts_q == TS_HEAD) || (ts_q == TS_TAIL);
  wire body_go  = in_body && !busy_q && rsp_valid;
  wire load     = !busy_q && (in_ack || in_cr || body_go);
  wire [7:0] load_chr = in_ack ? ACK_SEQ[ack_idx_q] :
                        in_cr  ? CHR_CR : rsp.data;
  wire load_par = (^load_chr) ^ PARITY_ODD;
  wire ack_end  = in_ack && load && (ack_idx_q == ACK_LAST);
  wire tcnt_z   = (tcnt_q == '0);
  wire [DIV_W-1:0] tdiv_m1 = bit_div - DIV_W'(1);

  assign rsp_ready = body_go;

  always_comb
  begin
    ts_d = ts_q;
    case (ts_q)
      TS_IDLE:
        if (start_ack)
          ts_d = TS_ACK;
        else if (start_rsp)
          ts_d = TS_HEAD;
      TS_ACK:   if (ack_end) ts_d = TS_DRAIN;
      TS_HEAD:  if (load) ts_d = TS_BODY;
      TS_BODY:  if (body_go && rsp.last) ts_d = TS_TAIL;
      TS_TAIL:  if (load) ts_d = TS_DRAIN;
      TS_DRAIN: if (!busy_q) ts_d = TS_IDLE;
      default:  ts_d = TS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      ts_q      <= TS_IDLE;
      ack_idx_q <= '0;
      drv_q     <= 1'b0;
    end
    else
    begin
      ts_q      <= ts_d;
      ack_idx_q <= start_ack ? 2'h0 : (in_ack && load ? ack_idx_q + 2'h1 : ack_idx_q);
      // driver on only while a reply is underway
      drv_q     <= (ts_d != TS_IDLE);
    end
  end

  // ------------------------------------------------------------
  // Transmit bit engine
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      busy_q <= 1'b0;
      sh_q   <= '1;
      tcnt_q <= '0;
      tbit_q <= '0;
    end
    else if (load)
    begin
      // start, data LSB first, parity, stop
      busy_q <= 1'b1;
      sh_q   <= {1'b1, load_par, load_chr, 1'b0};
      tcnt_q <= tdiv_m1;
      tbit_q <= TX_LAST_BIT;
    end
    else if (busy_q)
    begin
      if (!tcnt_z)
      begin
        tcnt_q <= tcnt_q - DIV_W'(1);
      end
      else if (tbit_q == 4'h0)
      begin
        busy_q <= 1'b0;
      end
      else
      begin
        sh_q   <= {1'b1, sh_q[10:1]};
        tbit_q <= tbit_q - 4'h1;
        tcnt_q <= tdiv_m1;
      end
    end
  end

  // transmit pair independent of receive pair
  assign txd    = sh_q[0];
  assign drv_en = drv_q;

endmodule : rsl_link_slave

// ---- testbench/rsl_link_slave_chk.sv ----
// Port assertions for the link slave
`timescale 1ns/1ps
module rsl_link_slave_chk
  import rsl_pkg::*;
#(
  parameter int DEPTH = CMD_DEPTH,
  parameter int AW    = CMD_AW
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              txd,
  input wire logic              drv_en,
  input wire logic              ack_req,
  input wire logic              rsp_valid,
  input wire logic              rate_wr,
  input wire logic [RATE_W-1:0] rate_code,
  input wire logic [RATE_W-1:0] bit_rate_setting,
  input wire logic              init_normal,
  input wire logic              init_total,
  input wire logic              cmd_valid,
  input wire logic [AW:0]       cmd_len,
  input wire logic              cmd_done,
  input wire logic              rx_err
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Line still idle when driver opens, start bit one cycle on
  sequence s_tx_open;
    txd ##1 !txd;
  endsequence

  AST_TX_START: assert property ($rose(drv_en) |-> s_tx_open)
    else $error("start bit not one cycle after driver enable");
  AST_NO_SPONT: assert property (!drv_en && !ack_req && !rsp_valid |=> !drv_en)
    else $error("driver opened without a request");
  AST_DRV_OFF: assert property (!drv_en |-> txd)
    else $error("line low while driver released");
  AST_DRV_HOLD: assert property ($fell(drv_en) |-> $past(txd) && $past(txd, 2))
    else $error("driver dropped before stop bit ended");
  AST_RATE_WR: assert property (rate_wr && rate_code <= RATE_CODE_MAX
    |=> bit_rate_setting == $past(rate_code))
    else $error("rate write not applied");
  AST_RATE_BAD: assert property (rate_wr && rate_code > RATE_CODE_MAX
    |=> $stable(bit_rate_setting))
    else $error("illegal rate code accepted");
  AST_RATE_MAX: assert property (bit_rate_setting <= RATE_CODE_MAX)
    else $error("rate setting out of range");
  AST_INIT_RATE: assert property (init_normal || init_total
    |-> bit_rate_setting == RATE_CODE_DEF ##1 !(init_normal || init_total))
    else $error("init did not restore default rate");
  AST_INIT_EXCL: assert property (!(init_normal && init_total))
    else $error("both init kinds at once");
  AST_CMD_HOLD: assert property (cmd_valid && !cmd_done |=> cmd_valid)
    else $error("command dropped before done");
  AST_CMD_FREE: assert property (cmd_valid && cmd_done |=> !cmd_valid)
    else $error("command not freed after done");
  AST_LEN_MAX: assert property (cmd_len <= DEPTH)
    else $error("command length beyond buffer");
  AST_ERR_PULSE: assert property (rx_err |=> !rx_err)
    else $error("error flag longer than one cycle");
endmodule : rsl_link_slave_chk

bind rsl_link_slave rsl_link_slave_chk #(.DEPTH(DEPTH), .AW(AW)) u_chk (
  .clk(clk), .rst_b(rst_b), .txd(txd), .drv_en(drv_en), .ack_req(ack_req),
  .rsp_valid(rsp_valid), .rate_wr(rate_wr), .rate_code(rate_code),
  .bit_rate_setting(bit_rate_setting), .init_normal(init_normal),
  .init_total(init_total), .cmd_valid(cmd_valid), .cmd_len(cmd_len),
  .cmd_done(cmd_done), .rx_err(rx_err));

// ---- testbench/rsl_master_model.sv ----
// Bus master model: sends command frames, decodes reply frames
`timescale 1ns/1ps
module rsl_master_model
  import rsl_pkg::*;
#(
  parameter int DIV = 5208
) (
  input  wire logic clk,
  output logic      rxd,
  input  wire logic txd,
  input  wire logic drv_en
);
  logic [7:0] got[$];
  logic [9:0] fr;
  // Released driver reads as the pull-up level
  wire        line = drv_en ? txd : 1'b1;

  initial rxd = 1'b1;

  task automatic send(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    f = {1'b1, (^d) ^ bad, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rxd = f[i];
      repeat (DIV) @(posedge clk);
      #1;
    end
  endtask : send

  // decode at mid-bit; a bad frame is stored as FF
  always
  begin
    @(negedge line);
    repeat (DIV / 2) @(posedge clk);
    for (int i = 0; i < 10; i++)
    begin
      repeat (DIV) @(posedge clk);
      fr[i] = line;
    end
    got.push_back((fr[9] && !(^fr[8:0])) ? fr[7:0] : 8'hFF);
  end
endmodule : rsl_master_model

// ---- testbench/rsl_link_slave_test.sv ----
// Self-checking bench for the link slave
`timescale 1ns/1ps
module rsl_link_slave_test;
  import rsl_pkg::*;
  typedef struct packed {
    logic dij; logic cpj; logic [2:0] saved; logic [2:0] rate; logic nrm; logic tot;
  } rsl_row_t;
  // Scaled clock rate gives short bit times at the fastest code
  localparam int unsigned TB_CLK = 307_200;
  localparam int          DIV    = TB_CLK / (BAUD_MIN << 4);
  localparam rsl_row_t ROWS[4] = '{
    '{1'h1, 1'h1, 3'h0, 3'h3, 1'h1, 1'h0}, '{1'h1, 1'h0, 3'h0, 3'h3, 1'h0, 1'h1},
    '{1'h0, 1'h0, 3'h4, 3'h4, 1'h0, 1'h0}, '{1'h0, 1'h0, 3'h7, 3'h3, 1'h0, 1'h0}};
  logic clk = 1'b0, rst_b, rxd, txd, drv_en, rate_wr, cmd_done, ack_req, rsp_valid;
  logic default_init_jumper, control_priority_jumper, init_normal, init_total;
  logic cmd_valid, rx_err, rsp_ready;
  logic [2:0] saved_rate_code, rate_code, bit_rate_setting;
  logic [5:0] cmd_len;
  logic [4:0] cmd_rd_addr;
  logic [7:0] cmd_rd_data;
  rsl_rsp_t   rsp;
  int n_mismatch = 0, cmp_count = 0, n_norm, n_tot, n_err;

  always #5 clk = ~clk;

  rsl_link_slave #(.CLK_FREQ(TB_CLK)) DUT (.clk(clk), .rst_b(rst_b), .rxd(rxd), .txd(txd),
    .drv_en(drv_en),
    .default_init_jumper(default_init_jumper),
    .control_priority_jumper(control_priority_jumper),
    .saved_rate_code(saved_rate_code), .rate_wr(rate_wr), .rate_code(rate_code),
    .bit_rate_setting(bit_rate_setting), .init_normal(init_normal),
    .init_total(init_total), .cmd_valid(cmd_valid), .cmd_len(cmd_len),
    .cmd_rd_addr(cmd_rd_addr), .cmd_rd_data(cmd_rd_data), .cmd_done(cmd_done),
    .rx_err(rx_err), .ack_req(ack_req), .rsp_valid(rsp_valid), .rsp(rsp),
    .rsp_ready(rsp_ready));
  // master set to the slave's rate
  rsl_master_model #(.DIV(DIV)) u_master (.clk(clk), .rxd(rxd), .txd(txd), .drv_en(drv_en));

  always @(posedge clk)
  begin
    n_norm += (init_normal === 1'b1);
    n_tot  += (init_total === 1'b1);
    n_err  += (rx_err === 1'b1);
  end

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Holds the body character until the slave takes it
  task automatic put_rsp(input logic last, input logic [7:0] d);
    rsp_valid = 1'b1;
    rsp = {last, d};
    for (int i = 0; i < 20 * DIV && rsp_ready !== 1'b1; i++) tick();
    cmp(8'(rsp_ready), 8'h01);
    tick();
  endtask : put_rsp

  task automatic summarize;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic do_reset(input rsl_row_t r);
    rst_b = 1'b0;
    default_init_jumper = r.dij;
    control_priority_jumper = r.cpj;
    saved_rate_code = r.saved;
    repeat (10) tick();
    n_norm = 0;
    n_tot = 0;
    rst_b = 1'b1;
    repeat (8) tick();
  endtask : do_reset

  initial
  begin
    {rate_wr, rate_code, cmd_done, ack_req, rsp_valid, rsp, cmd_rd_addr} = '0;
    // Jumper and saved-rate cases
    foreach (ROWS[i])
    begin
      do_reset(ROWS[i]);
      cmp(8'(bit_rate_setting), 8'(ROWS[i].rate));
      cmp(8'(n_norm), 8'(ROWS[i].nrm));
      cmp(8'(n_tot), 8'(ROWS[i].tot));
    end
    // Every rate code, then one out of range
    for (int c = 0; c < 6; c++)
    begin
      rate_code = 3'(c);
      rate_wr = 1'b1;
      tick();
      rate_wr = 1'b0;
      tick();
      cmp(8'(bit_rate_setting), 8'(c > 4 ? 4 : c));
    end
    // Request with no command owed
    ack_req = 1'b1;
    tick();
    ack_req = 1'b0;
    repeat (20) tick();
    cmp(8'(drv_en), 8'h00);
    // Bad parity dropped, then a one-char command
    n_err = 0;
    u_master.send(8'h55, 1'b1);
    cmp(8'(n_err), 8'h01);
    cmp(8'(cmd_valid), 8'h00);
    u_master.send(8'h41, 1'b0);
    u_master.send(CHR_CR, 1'b0);
    for (int i = 0; i < 50 && cmd_valid !== 1'b1; i++) tick();
    cmp(8'(cmd_valid), 8'h01);
    cmp(8'(cmd_len), 8'h01);
    repeat (2) tick();
    cmp(cmd_rd_data, 8'h41);
    // Acknowledge, freeing the buffer as it starts
    ack_req = 1'b1;
    tick();
    ack_req = 1'b0;
    cmd_done = 1'b1;
    tick();
    cmd_done = 1'b0;
    tick();
    cmp(8'(cmd_valid), 8'h00);
    cmp(8'(drv_en), 8'h01);
    // Next command arrives while the acknowledge is still going out
    fork
      begin
        u_master.send(8'h42, 1'b0);
        u_master.send(CHR_CR, 1'b0);
      end
    join_none
    for (int i = 0; i < 60 * DIV && drv_en !== 1'b0; i++) tick();
    cmp(8'(drv_en), 8'h00);
    cmp(8'(u_master.got.size()), 8'h04);
    for (int i = 0; i < 4; i++) cmp(u_master.got[i], ACK_SEQ[i]);
    cmp(8'(cmd_valid), 8'h01);
    cmp(8'(cmd_len), 8'h01);
    cmp(cmd_rd_data, 8'h42);
    // Response body wrapped in carriage returns
    cmd_done = 1'b1;
    tick();
    cmd_done = 1'b0;
    put_rsp(1'b0, 8'h31);
    put_rsp(1'b1, 8'h32);
    rsp_valid = 1'b0;
    for (int i = 0; i < 40 * DIV && drv_en !== 1'b0; i++) tick();
    cmp(8'(drv_en), 8'h00);
    cmp(8'(u_master.got.size()), 8'h08);
    cmp(u_master.got[4], CHR_CR);
    cmp(u_master.got[5], 8'h31);
    cmp(u_master.got[6], 8'h32);
    cmp(u_master.got[7], CHR_CR);
    summarize();
  end

  // Whole run takes near 2100 cycles; about five times that means a hang
  initial
  begin
    repeat (10_000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule : rsl_link_slave_test
